/* File: aspc_defs.vh */
// constants shared by the alert and shutdown pin control block
`ifndef ASPC_DEFS_VH
`define ASPC_DEFS_VH
// control subcommand codes
`define ASPC_CMD_W            16
`define ASPC_CMD_ARM          16'h0013
`define ASPC_CMD_DISARM       16'h0014
// power mode encodings
`define ASPC_MODE_W           2
`define ASPC_MODE_NORMAL      2'h0
`define ASPC_MODE_SLEEP       2'h1
`define ASPC_MODE_FULLSLEEP   2'h2
`define ASPC_MODE_HIBERNATE   2'h3
// fault flag vector positions
`define ASPC_NFLT             8
`define ASPC_F_CHARGE_LEVEL_ALERT           0
`define ASPC_F_BATTERY_HIGH_FLAG          1
`define ASPC_F_BATTERY_LOW_FLAG         2
`define ASPC_F_OTC            3
`define ASPC_F_OTD            4
`define ASPC_F_ISD            5
`define ASPC_F_TDD            6
`define ASPC_F_IMAX           7
`endif

/* File: aspc_sync.v */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module aspc_sync #(
	parameter RST_VAL = 1'b0
) (
	// clock and reset
	input  wire i_clk,
	input  wire i_reset_n,
	// data
	input  wire i_d,
	output wire o_q
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	reg q_reg;

	// first stage feeds only the second stage
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			q_reg  <= RST_VAL;
		end else begin
			s1_reg <= i_d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				q_reg <= s2_reg;
			end
		end
	end

	assign o_q = q_reg;
endmodule

/* File: aspc_pin_drive.v */
// pin level encoder: pull-up and polarity to output and enable
`timescale 1ns/1ns
module aspc_pin_drive (
	// settings
	input  wire i_pullup,
	input  wire i_pol,
	input  wire i_active,
	// pin drive
	output reg  o_out,
	output reg  o_oe
);
	// pullup/pol 00: Z/0, 01: 0/Z, 10: 1/0, 11: 0/1 (inactive/active)
	always @* begin
		o_out = 1'b0;
		o_oe  = 1'b1;
		case ({i_pullup, i_pol})
			2'h0: o_oe = i_active;
			2'h1: o_oe = ~i_active;
			2'h2: o_out = ~i_active;
			2'h3: o_out = i_active;
			default: o_oe = 1'b0;
		endcase
	end
endmodule

/* File: aspc_top.v */
// alert and shutdown pin control: event pin interrupt/shutdown and link pin interrupt
`timescale 1ns/1ns
`include "aspc_defs.vh"
module aspc_top #(
	parameter CAP_W   = 16,
	parameter DELAY_W = 8
) (
	// clock and reset
	input  wire                    i_clk,
	input  wire                    i_reset_n,
	// configuration bits
	input  wire                    i_int_pin_select,
	input  wire                    i_shutdown_feature_enable,
	input  wire                    i_event_pin_pullup,
	input  wire                    i_shutdown_polarity,
	input  wire                    i_interrupt_polarity,
	input  wire                    i_short_irq_enable,
	input  wire                    i_tab_irq_enable,
	input  wire                    i_max_current_irq_enable,
	input  wire                    i_trip_point_enable,
	input  wire [DELAY_W-1:0]      i_overtemp_charge_delay,
	input  wire [DELAY_W-1:0]      i_overtemp_discharge_delay,
	// fault flags from the gauge
	input  wire                    i_charge_level_alert,
	input  wire                    i_battery_high_flag,
	input  wire                    i_battery_low_flag,
	input  wire                    i_overtemp_charge_flag,
	input  wire                    i_overtemp_discharge_flag,
	input  wire                    i_internal_short_flag,
	input  wire                    i_tab_disconnect_flag,
	input  wire                    i_max_current_flag,
	// trip point inputs
	input  wire [CAP_W-1:0]        i_remaining_charge,
	input  wire                    i_discharging,
	input  wire                    i_charging,
	input  wire                    i_trip_set_wr,
	input  wire                    i_trip_clear_wr,
	input  wire [CAP_W-1:0]        i_trip_wdata,
	// control command
	input  wire                    i_cmd_valid,
	input  wire [`ASPC_CMD_W-1:0]  i_cmd_code,
	// power mode
	input  wire [`ASPC_MODE_W-1:0] i_power_mode,
	input  wire                    i_hib_low_voltage,
	// status
	output wire                    o_shutdown_request_flag,
	output wire                    o_event_status,
	output wire                    o_trip_active,
	output wire [CAP_W-1:0]        o_trip_set_threshold,
	output wire [CAP_W-1:0]        o_trip_clear_threshold,
	// system event pin
	output wire                    o_system_event_pin_out,
	output wire                    o_system_event_pin_oe,
	// single wire host link pin interrupt drive
	output wire                    o_link_pin_out,
	output wire                    o_link_pin_oe
);
	// ==========================================================
	// state
	reg              shutdown_request_flag_reg;
	reg              sfe_prev_reg;
	reg              pullup_applied_reg;
	reg              por_done_reg;
	reg              irq_reg;
	reg              trip_latch_reg;
	reg              set_wr_seen_reg;
	reg              clr_wr_seen_reg;
	reg [CAP_W-1:0]  trip_set_reg;
	reg [CAP_W-1:0]  trip_clr_reg;
	reg              se_out_reg;
	reg              se_oe_reg;
	reg              link_out_reg;
	reg              link_oe_reg;

	wire hib_sync;
	wire [`ASPC_NFLT-1:0] flags;
	wire [`ASPC_NFLT-1:0] enables;
	reg                   shutdown_request_flag_next;
	reg                   se_out_next;
	reg                   se_oe_next;
	reg                   link_out_next;
	reg                   link_oe_next;
	wire                  cmd_arm;
	wire                  cmd_disarm;
	wire                  sfe_rise;
	wire                  sfe_fall;
	wire                  trip_low_hit;
	wire                  trip_high_hit;
	reg                   trip_latch_next;
	reg                   irq_next;
	wire                  trip_hit;
	wire                  trip_release;
	wire                  sd_mode;
	wire                  sd_active;
	wire                  int_out;
	wire                  int_oe;
	wire                  sd_out;
	wire                  sd_oe;

	// ==========================================================
	// low-voltage hibernate indicator comes from another domain
	aspc_sync #(
		.RST_VAL (1'b0)
	) u_hib_sync (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_d       (i_hib_low_voltage),
		.o_q       (hib_sync)
	);

	// ==========================================================
	// shutdown arming
	// control subcommand decode; unknown codes are ignored
	assign cmd_arm    = i_cmd_valid && (i_cmd_code == `ASPC_CMD_ARM);
	assign cmd_disarm = i_cmd_valid && (i_cmd_code == `ASPC_CMD_DISARM);
	// enable edges against the value seen at the previous edge
	assign sfe_rise   = !sfe_prev_reg && i_shutdown_feature_enable;
	assign sfe_fall   = sfe_prev_reg && !i_shutdown_feature_enable;

	always @* begin
		shutdown_request_flag_next = shutdown_request_flag_reg;
		if (cmd_disarm) begin
			shutdown_request_flag_next = 1'b0;
		end
		if (sfe_fall) begin
			shutdown_request_flag_next = 1'b0;
		end
		// arming wins over a disarm in the same cycle
		if (cmd_arm) begin
			shutdown_request_flag_next = 1'b1;
		end
		if (sfe_rise) begin
			shutdown_request_flag_next = 1'b1;
		end
	end

	// ==========================================================
	// fault sources and enables
	assign flags = {i_max_current_flag, i_tab_disconnect_flag,
		i_internal_short_flag, i_overtemp_discharge_flag,
		i_overtemp_charge_flag, i_battery_low_flag,
		i_battery_high_flag, i_charge_level_alert};

	assign enables[`ASPC_F_CHARGE_LEVEL_ALERT]   = 1'b1;
	assign enables[`ASPC_F_BATTERY_HIGH_FLAG]  = 1'b1;
	assign enables[`ASPC_F_BATTERY_LOW_FLAG] = 1'b1;
	assign enables[`ASPC_F_OTC]    = |i_overtemp_charge_delay;
	assign enables[`ASPC_F_OTD]    = |i_overtemp_discharge_delay;
	assign enables[`ASPC_F_ISD]    = i_short_irq_enable;
	assign enables[`ASPC_F_TDD]    = i_tab_irq_enable;
	assign enables[`ASPC_F_IMAX]   = i_max_current_irq_enable;

	// ==========================================================
	// trip point
	// discharge side: at or below the set threshold
	assign trip_low_hit  = i_discharging &&
		(i_remaining_charge <= trip_set_reg);
	// charge side: at or above the clear threshold
	assign trip_high_hit = i_charging &&
		(i_remaining_charge >= trip_clr_reg);
	assign trip_hit = trip_low_hit || trip_high_hit;
	// release needs both thresholds rewritten since the trip
	assign trip_release = (set_wr_seen_reg || i_trip_set_wr) &&
		(clr_wr_seen_reg || i_trip_clear_wr);

	always @* begin
		trip_latch_next = trip_latch_reg;
		if (!i_trip_point_enable) begin
			trip_latch_next = 1'b0;
		end else if (trip_latch_reg && trip_release) begin
			trip_latch_next = 1'b0;
		end else if (trip_hit) begin
			trip_latch_next = 1'b1;
		end
	end

	// ==========================================================
	// interrupt combine
	always @* begin
		if (i_trip_point_enable) begin
			irq_next = trip_latch_next;
		end else begin
			irq_next = |(flags & enables);
		end
	end

	// ==========================================================
	// pin mode selection
	assign sd_mode = i_int_pin_select &&
		(i_shutdown_feature_enable || shutdown_request_flag_reg);
	// armed pin stays normal outside low-voltage hibernate
	assign sd_active = sd_mode && hib_sync &&
		(i_power_mode == `ASPC_MODE_HIBERNATE);

	aspc_pin_drive u_int_drive (
		.i_pullup (pullup_applied_reg),
		.i_pol    (i_interrupt_polarity),
		.i_active (irq_reg),
		.o_out    (int_out),
		.o_oe     (int_oe)
	);

	aspc_pin_drive u_sd_drive (
		.i_pullup (pullup_applied_reg),
		.i_pol    (i_shutdown_polarity),
		.i_active (sd_active),
		.o_out    (sd_out),
		.o_oe     (sd_oe)
	);

	// ==========================================================
	// pin drive selection
	// precedence: power-on hold, then shutdown use, then interrupt use
	always @* begin
		se_out_next = 1'b0;
		se_oe_next  = 1'b0;
		if (!por_done_reg) begin
			se_out_next = 1'b0;
			se_oe_next  = 1'b0;
		end else if (sd_mode) begin
			se_out_next = sd_out;
			se_oe_next  = sd_oe;
		end else if (!i_int_pin_select) begin
			se_out_next = int_out;
			se_oe_next  = int_oe;
		end else begin
			se_out_next = 1'b0;
			se_oe_next  = 1'b0;
		end
	end

	// link pin is open drain: only low or released
	always @* begin
		link_out_next = 1'b0;
		link_oe_next  = i_int_pin_select &&
			(irq_next ^ i_interrupt_polarity);
	end

	// ==========================================================
	// arming and pull-up registers
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			shutdown_request_flag_reg <= 1'b0;
			sfe_prev_reg       <= 1'b0;
			pullup_applied_reg <= 1'b0;
			por_done_reg       <= 1'b0;
		end else begin
			shutdown_request_flag_reg <= shutdown_request_flag_next;
			sfe_prev_reg <= i_shutdown_feature_enable;
			por_done_reg <= 1'b1;
			// pull-up is caught once after reset release only
			if (!por_done_reg) begin
				pullup_applied_reg <= i_event_pin_pullup;
			end
		end
	end

	// ==========================================================
	// pin registers
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			se_out_reg   <= 1'b0;
			se_oe_reg    <= 1'b0;
			link_out_reg <= 1'b0;
			link_oe_reg  <= 1'b0;
		end else begin
			se_out_reg   <= se_out_next;
			se_oe_reg    <= se_oe_next;
			link_out_reg <= link_out_next;
			link_oe_reg  <= link_oe_next;
		end
	end

	// ==========================================================
	// interrupt and trip registers
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			irq_reg            <= 1'b0;
			trip_latch_reg     <= 1'b0;
			set_wr_seen_reg    <= 1'b0;
			clr_wr_seen_reg    <= 1'b0;
			trip_set_reg       <= {CAP_W{1'b0}};
			trip_clr_reg       <= {CAP_W{1'b1}};
		end else begin
			irq_reg        <= irq_next;
			trip_latch_reg <= trip_latch_next;
			if (i_trip_set_wr) begin
				trip_set_reg <= i_trip_wdata;
			end
			if (i_trip_clear_wr) begin
				trip_clr_reg <= i_trip_wdata;
			end
			// write tracking restarts each time the trip latches
			if (!trip_latch_reg && trip_latch_next) begin
				set_wr_seen_reg <= 1'b0;
				clr_wr_seen_reg <= 1'b0;
			end else begin
				if (i_trip_set_wr) begin
					set_wr_seen_reg <= 1'b1;
				end
				if (i_trip_clear_wr) begin
					clr_wr_seen_reg <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// outputs; status bits ignore the pin selection
	assign o_shutdown_request_flag = shutdown_request_flag_reg;
	assign o_event_status          = irq_reg;
	assign o_trip_active           = trip_latch_reg;
	assign o_trip_set_threshold    = trip_set_reg;
	assign o_trip_clear_threshold  = trip_clr_reg;
	assign o_system_event_pin_out  = se_out_reg;
	assign o_system_event_pin_oe   = se_oe_reg;
	assign o_link_pin_out          = link_out_reg;
	assign o_link_pin_oe           = link_oe_reg;
endmodule

/* File: aspc_props.sv */
// concurrent checks on the pin control block's ports
`timescale 1ns/1ns
`include "aspc_defs.vh"
module aspc_props (
	// clock, reset and settings
	input wire       i_clk, i_reset_n, i_int_pin_select,
	input wire       i_shutdown_feature_enable, i_event_pin_pullup,
	input wire       i_shutdown_polarity, i_interrupt_polarity,
	input wire       i_trip_point_enable, i_battery_low_flag,
	// commands and writes
	input wire       i_cmd_valid, i_trip_set_wr, i_trip_clear_wr,
	input wire [`ASPC_CMD_W-1:0] i_cmd_code,
	input wire [1:0] i_power_mode,
	// block outputs
	input wire       o_shutdown_request_flag, o_event_status,
	input wire       o_trip_active, o_system_event_pin_oe,
	input wire       o_link_pin_out, o_link_pin_oe
);
	reg [1:0] age_reg;
	reg       pu_reg;
	// pull-up is latched once per reset, so keep the same copy here
	always @(posedge i_clk) begin
		age_reg <= !i_reset_n ? 2'h0 : age_reg + {1'b0, age_reg != 2'h3};
		if (i_reset_n && age_reg == 2'h0)
			pu_reg <= i_event_pin_pullup;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	property p_arm;
		i_cmd_valid && i_cmd_code == `ASPC_CMD_ARM
			|=> o_shutdown_request_flag;
	endproperty
	a_arm: assert property (p_arm) else $error("arm lost");
	property p_dis;
		i_cmd_valid && i_cmd_code == `ASPC_CMD_DISARM &&
			$stable(i_shutdown_feature_enable) |=> !o_shutdown_request_flag;
	endproperty
	a_dis: assert property (p_dis) else $error("disarm lost");
	property p_fall;
		$fell(i_shutdown_feature_enable) && !i_cmd_valid
			|=> !o_shutdown_request_flag;
	endproperty
	a_fall: assert property (p_fall) else $error("enable fall");
	property p_low;
		i_battery_low_flag && !i_trip_point_enable |=> o_event_status;
	endproperty
	a_low: assert property (p_low) else $error("low not seen");
	property p_link;
		age_reg == 2'h3 |-> !o_link_pin_out && o_link_pin_oe ==
			($past(i_int_pin_select) &&
			o_event_status != $past(i_interrupt_polarity));
	endproperty
	a_link: assert property (p_link) else $error("link pin");
	// must hold while reset is low, so reset cannot disable it
	property p_por;
		disable iff (1'b0)
		!i_reset_n |=> !o_system_event_pin_oe && !o_link_pin_oe;
	endproperty
	a_por: assert property (p_por) else $error("pin driven");
	property p_norm;
		(age_reg == 2'h3 && i_int_pin_select && o_shutdown_request_flag &&
			i_power_mode != `ASPC_MODE_HIBERNATE &&
			$stable(i_shutdown_polarity))[*3]
			|-> o_system_event_pin_oe == (pu_reg | i_shutdown_polarity);
	endproperty
	a_norm: assert property (p_norm) else $error("not normal");
	property p_hold;
		o_trip_active && i_trip_point_enable && !i_trip_set_wr &&
			!i_trip_clear_wr |=> o_trip_active;
	endproperty
	a_hold: assert property (p_hold) else $error("trip dropped");
	c_arm: cover property (i_cmd_valid && i_cmd_code == `ASPC_CMD_ARM);
	c_trip: cover property ($rose(o_trip_active));
	c_sd: cover property (i_power_mode == 2'h3 && o_system_event_pin_oe);
endmodule
bind aspc_top aspc_props u_props (.*);

/* File: aspc_host_model.sv */
// board side of both pins: pull-ups seen by host and power-off circuit
`timescale 1ns/1ns
module aspc_host_model (
	// pin drive from the block
	input  wire i_evt_out, i_evt_oe, i_link_out, i_link_oe,
	// levels on the board
	output wire o_evt_level, o_link_level
);
	// released lines float up through the board pull-ups
	assign o_evt_level  = i_evt_oe ? i_evt_out : 1'b1;
	assign o_link_level = i_link_oe ? i_link_out : 1'b1;
endmodule

/* File: tb_top.sv */
// self-checking bench: random and directed traffic against a reference
`timescale 1ns/1ns
`include "aspc_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
	reg        clk = 0, rst_n = 0, sel = 0, en = 0, pu = 0, spol = 0;
	reg        ipol = 0, isd_en = 0, tdd_en = 0, imx_en = 0, tp_en = 0;
	reg        dis = 0, chg = 0, swr = 0, cwr = 0, cv = 0, hib = 0;
	reg  [7:0] otc_d = 0, otd_d = 0, flt = 0;
	reg [15:0] rem = 0, wd = 0, code = 0;
	reg  [1:0] mode = 0;
	wire       flag, st, tact, eo, eoe, lo, loe, elev, llev;
	wire [15:0] sthr, cthr;
	integer    fail_count = 0, compares = 0, seed = 32'h56197F4B, cyc = 0;
	integer    i, k;
	reg        m_flag, m_trip, m_ws, m_wc, m_en, m_pu, x, a, e_oe, l_oe;
	reg [15:0] m_set, m_clr;
	aspc_top DUT (.i_clk(clk), .i_reset_n(rst_n), .i_int_pin_select(sel),
		.i_shutdown_feature_enable(en), .i_event_pin_pullup(pu),
		.i_shutdown_polarity(spol), .i_interrupt_polarity(ipol),
		.i_short_irq_enable(isd_en), .i_tab_irq_enable(tdd_en),
		.i_max_current_irq_enable(imx_en), .i_trip_point_enable(tp_en),
		.i_overtemp_charge_delay(otc_d), .i_overtemp_discharge_delay(otd_d),
		.i_charge_level_alert(flt[0]), .i_battery_high_flag(flt[1]),
		.i_battery_low_flag(flt[2]), .i_overtemp_charge_flag(flt[3]),
		.i_overtemp_discharge_flag(flt[4]), .i_internal_short_flag(flt[5]),
		.i_tab_disconnect_flag(flt[6]), .i_max_current_flag(flt[7]),
		.i_remaining_charge(rem), .i_discharging(dis), .i_charging(chg),
		.i_trip_set_wr(swr), .i_trip_clear_wr(cwr), .i_trip_wdata(wd),
		.i_cmd_valid(cv), .i_cmd_code(code), .i_power_mode(mode),
		.i_hib_low_voltage(hib), .o_shutdown_request_flag(flag),
		.o_event_status(st), .o_trip_active(tact),
		.o_trip_set_threshold(sthr), .o_trip_clear_threshold(cthr),
		.o_system_event_pin_out(eo), .o_system_event_pin_oe(eoe),
		.o_link_pin_out(lo), .o_link_pin_oe(loe));
	aspc_host_model PM (.i_evt_out(eo), .i_evt_oe(eoe), .i_link_out(lo),
		.i_link_oe(loe), .o_evt_level(elev), .o_link_level(llev));
	initial forever #50 clk = ~clk;
	// reference: arm/disarm flag and trip latch
	always @(posedge clk) begin
		if (!rst_n) begin
			{m_flag, m_trip, m_ws, m_wc, m_en, m_pu} = {5'h0, pu};
			m_set = 16'h0;
			m_clr = 16'hFFFF;
		end else begin
			if ((cv && code == `ASPC_CMD_ARM) || (en && !m_en)) m_flag = 1;
			else if ((cv && code == `ASPC_CMD_DISARM) || (!en && m_en))
				m_flag = 0;
			m_en = en;
			if (!tp_en) {m_trip, m_ws, m_wc} = 3'h0;
			else if (m_trip) begin
				m_ws = m_ws | swr;
				m_wc = m_wc | cwr;
				if (m_ws && m_wc) {m_trip, m_ws, m_wc} = 3'h0;
			end else if ((dis && rem <= m_set) || (chg && rem >= m_clr))
				m_trip = 1;
			if (swr) m_set = wd;
			if (cwr) m_clr = wd;
		end
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 2500) begin fail_count++; print_verdict; end
	end
	task print_verdict;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task step(input integer n); repeat (n) @(negedge clk); endtask
	task reset_dut(input p);
		rst_n = 0; pu = p; en = 0; sel = 0; step(2);
		`CHK({eoe, loe}, 2'h0)
		rst_n = 1; step(2); pu = !p;
	endtask
	task cmd(input [15:0] c); cv = 1; code = c; step(1); cv = 0; endtask
	task wr(input s, input c, input [15:0] v);
		swr = s; cwr = c; wd = v; step(1); swr = 0; cwr = 0;
	endtask
	task chk;
		step(8);
		x = tp_en ? m_trip : |(flt & {imx_en, tdd_en, isd_en, otd_d != 0,
			otc_d != 0, 3'h7});
		a = sel ? (mode == 2'h3 && hib) ^ spol : x ^ ipol;
		e_oe = (!sel || m_flag || en) && (m_pu || a);
		l_oe = sel && (x ^ ipol);
		`CHK({flag, st}, {m_flag, x})
		`CHK({tact, sthr, cthr}, {m_trip, m_set, m_clr})
		`CHK({eoe, elev}, {e_oe, e_oe ? m_pu && !a : 1'b1})
		`CHK({loe, llev, lo}, {l_oe, !l_oe, 1'b0})
	endtask
	initial begin
		reset_dut(0); chk; $display("reset test done");
		for (i = 0; i < 40; i = i + 1) begin
			{sel, ipol, isd_en, tdd_en, imx_en, en} = $random(seed);
			flt = $random(seed); rem = $random(seed);
			otc_d = $random(seed) & 3; otd_d = $random(seed) & 3; chk;
		end
		$display("fault test done");
		en = 0; cmd(`ASPC_CMD_ARM); chk; cmd(16'h0015); chk;
		cmd(`ASPC_CMD_DISARM); chk;
		cv = 1; code = `ASPC_CMD_ARM; step(1); code = `ASPC_CMD_DISARM;
		step(1); cv = 0; chk; en = 1; chk; cmd(`ASPC_CMD_DISARM); chk;
		en = 0; chk; $display("command test done");
		for (k = 0; k < 2; k = k + 1) begin
			reset_dut(k); sel = 1; flt = 8'h04; cmd(`ASPC_CMD_ARM);
			for (i = 0; i < 16; i = i + 1) begin
				{spol, mode, hib} = i; ipol = $random(seed); chk;
			end
		end
		$display("shutdown test done");
		tp_en = 1; dis = 1; rem = 16'h0064; flt = 8'hFF; sel = 0;
		wr(1, 0, 16'h0032); chk; rem = 16'h0028; chk; rem = 16'h0064; chk;
		wr(1, 0, 16'h001E); chk; wr(0, 1, 16'h00C8); chk;
		dis = 0; chg = 1; rem = 16'h00FA; chk; wr(1, 1, 16'h0100); chk;
		tp_en = 0; chk; $display("trip test done");
		print_verdict;
	end
endmodule
